// [rtl/agc_debounce_status.sv]
`default_nettype none
module agc_debounce_status
    import agc_status_pkg::*;
#(
    parameter int unsigned half_ms_cycles = HALF_MS_CYCLES
)
(
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata_r,
    output logic pready_r,
    output logic pslverr_r,
    // gain loop state, same clock
    input wire logic [7:0] left_applied_gain,
    input wire logic [7:0] right_applied_gain,
    input wire logic [7:0] left_programmed_gain,
    input wire logic [7:0] right_programmed_gain,
    input wire logic left_adc_powered,
    input wire logic right_adc_powered,
    // signal power as attenuation below full scale in dB
    input wire logic [6:0] left_level_atten,
    input wire logic [6:0] right_level_atten,
    // detection results and interrupt
    output logic left_below_r,
    output logic right_below_r,
    output logic irq_r
);
    // ****************************************
    // register storage
    // ****************************************
    logic [7:0] deb_r [2];
    logic [4:0] thr_r [2];
    logic [6:0] maxg_r [2];
    logic dra_r;
    logic [3:0] sts_r;
    logic [3:0] mask_r;
    logic [7:0] flags;
    logic [1:0] below_raw;
    logic [1:0] below_db;
    logic [1:0] sat;
    logic [1:0] sat_q_r;
    logic [1:0] below_q_r;
    logic [3:0] events;
    logic [7:0] idx;
    logic aligned;
    logic setup;
    logic wr_done;
    logic [31:0] rd_nxt;
    logic mapped;
    logic [7:0] gain_in [2];
    logic [7:0] prog_in [2];
    logic [6:0] lvl_in [2];
    logic pwr_in [2];

    assign gain_in[0] = left_applied_gain;
    assign gain_in[1] = right_applied_gain;
    assign prog_in[0] = left_programmed_gain;
    assign prog_in[1] = right_programmed_gain;
    assign lvl_in[0] = left_level_atten;
    assign lvl_in[1] = right_level_atten;
    assign pwr_in[0] = left_adc_powered;
    assign pwr_in[1] = right_adc_powered;

    // ****************************************
    // apb decode
    // ****************************************
    assign idx = paddr[9:2];
    assign aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
    assign setup = psel && !penable;
    assign wr_done = psel && penable && pready_r && pwrite;

    // every access completes in its first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r <= 1'b0;
        end
        else
        begin
            pready_r <= setup;
        end
    end

    // ****************************************
    // time base
    // ****************************************
    logic [14:0] tick_cnt_r;
    logic tick_r;
    logic [14:0] tick_last;

    // double rate runs the audio twice as fast, so the debounce tick period halves
    assign tick_last = dra_r ? 15'((half_ms_cycles >> 1) - 1) : 15'(half_ms_cycles - 1);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt_r <= 15'h0000;
            tick_r <= 1'b0;
        end
        else if (tick_cnt_r >= tick_last)
        begin
            tick_cnt_r <= 15'h0000;
            tick_r <= 1'b1;
        end
        else
        begin
            tick_cnt_r <= tick_cnt_r + 15'h0001;
            tick_r <= 1'b0;
        end
    end

    // ****************************************
    // per-channel detection
    // ****************************************
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_ch
            logic [7:0] thr_db;
            logic [6:0] maxg_eff;
            // code n means -(28 + 2n) dB below full scale
            assign thr_db = 8'(THR_BASE_DB) + 8'(THR_STEP_DB) * {3'b000, thr_r[ch]};
            assign below_raw[ch] = {1'b0, lvl_in[ch]} > thr_db;
            // codes past 59.5 dB all mean 59.5 dB
            assign maxg_eff = (maxg_r[ch] > MAXG_TOP) ? MAXG_TOP : maxg_r[ch];
            assign sat[ch] = gain_in[ch] == {1'b0, maxg_eff};

            agc_gate_debounce u_deb
            (
                .pclk(pclk),
                .presetn(presetn),
                .tick(tick_r),
                .enable(thr_r[ch] != THR_RESET),
                .noise_code(deb_r[ch][7:NOISE_LSB]),
                .signal_code(deb_r[ch][2:0]),
                .raw_below(below_raw[ch]),
                .flag_r(below_db[ch])
            );
        end
    endgenerate

    // flag register: left in the upper nibble, right in the lower
    assign flags = {prog_in[0] == gain_in[0], pwr_in[0], below_db[0], sat[0],
                    prog_in[1] == gain_in[1], pwr_in[1], below_db[1], sat[1]};

    // ****************************************
    // software-written registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            deb_r[0] <= DEB_RESET;
            deb_r[1] <= DEB_RESET;
            thr_r[0] <= THR_RESET;
            thr_r[1] <= THR_RESET;
            maxg_r[0] <= MAXG_RESET;
            maxg_r[1] <= MAXG_RESET;
            dra_r <= 1'b0;
            mask_r <= IRQ_RESET;
        end
        else if (wr_done && aligned)
        begin
            case (idx)
                IDX_LDEB: deb_r[0] <= pwdata[7:0];
                IDX_RDEB: deb_r[1] <= pwdata[7:0];
                IDX_CTRL: dra_r <= pwdata[CTRL_DRA_BIT];
                IDX_LCFG:
                begin
                    thr_r[0] <= pwdata[THR_LSB +: 5];
                    maxg_r[0] <= pwdata[MAXG_LSB +: 7];
                end
                IDX_RCFG:
                begin
                    thr_r[1] <= pwdata[THR_LSB +: 5];
                    maxg_r[1] <= pwdata[MAXG_LSB +: 7];
                end
                IDX_IRQ_MASK: mask_r <= pwdata[3:0];
                default: ;
            endcase
        end
    end

    // ****************************************
    // interrupt status
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            below_q_r <= 2'b00;
            sat_q_r <= 2'b00;
        end
        else
        begin
            below_q_r <= below_db;
            sat_q_r <= sat;
        end
    end

    // events: detection changed per channel, saturation entered per channel
    assign events = {sat & ~sat_q_r, below_db ^ below_q_r};

    // a new event in the clearing cycle keeps its bit set
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sts_r <= IRQ_RESET;
        end
        else if (wr_done && aligned && idx == IDX_IRQ_STS)
        begin
            sts_r <= (sts_r & ~pwdata[3:0]) | events;
        end
        else
        begin
            sts_r <= sts_r | events;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_r <= 1'b0;
            left_below_r <= 1'b0;
            right_below_r <= 1'b0;
        end
        else
        begin
            irq_r <= |(sts_r & mask_r);
            left_below_r <= below_db[0];
            right_below_r <= below_db[1];
        end
    end

    // ****************************************
    // read path
    // ****************************************
    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        mapped = aligned;
        case (idx)
            IDX_RGAIN: rd_nxt[7:0] = right_applied_gain;
            IDX_LDEB: rd_nxt[7:0] = deb_r[0];
            IDX_RDEB: rd_nxt[7:0] = deb_r[1];
            IDX_FLAGS: rd_nxt[7:0] = flags;
            IDX_CTRL: rd_nxt[CTRL_DRA_BIT] = dra_r;
            IDX_LCFG: rd_nxt[14:0] = {maxg_r[0], 3'b000, thr_r[0]};
            IDX_RCFG: rd_nxt[14:0] = {maxg_r[1], 3'b000, thr_r[1]};
            IDX_IRQ_STS: rd_nxt[3:0] = sts_r;
            IDX_IRQ_MASK: rd_nxt[3:0] = mask_r;
            default: mapped = 1'b0;
        endcase
    end

    // data and error are captured in the setup cycle, held through access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else if (setup)
        begin
            prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
            pslverr_r <= !mapped;
        end
        else if (!psel)
        begin
            pslverr_r <= 1'b0;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_zero_wait: assert property (setup |=> pready_r ##1 !pready_r) else $error("pready not one cycle");
    a_gain_read: assert property (setup && !pwrite && aligned && idx == IDX_RGAIN
        |=> prdata_r == {24'h000000, $past(right_applied_gain)}) else $error("gain readback wrong");
    a_flag_read: assert property (setup && !pwrite && aligned && idx == IDX_FLAGS
        |=> prdata_r[7] == ($past(left_applied_gain) == $past(left_programmed_gain))
        && prdata_r[2] == $past(right_adc_powered)) else $error("flag readback wrong");
    a_sat_reset: assert property ($rose(presetn) |-> maxg_r[0] == MAXG_RESET && maxg_r[1] == MAXG_RESET)
        else $error("max gain reset wrong");
    a_sat_flag: assert property (right_applied_gain == {1'b0, MAXG_TOP} && maxg_r[1] == MAXG_RESET |-> flags[0])
        else $error("saturation missed at top code");
    a_dra_tick: assert property (dra_r && $stable(dra_r) && tick_r |-> tick_cnt_r == 15'h0000
        ##1 (!tick_r) [*2]) else $error("tick malformed");
    a_irq_level: assert property (##1 irq_r == $past(|(sts_r & mask_r))) else $error("irq level wrong");
    a_event_wins: assert property (|events |=> |(sts_r & $past(events))) else $error("event lost");
    a_unmapped_err: assert property (setup && !aligned |=> pslverr_r && pready_r) else $error("no error");
    a_thr_disable: assert property (thr_r[1] == THR_RESET |=> !below_db[1]) else $error("detect while off");
endmodule
`default_nettype wire

// [include/agc_status_pkg.sv]
// What this block does
// - right applied gain reads back as signed 8-bit half-dB value, -12.0 to +59.5 dB
// - left noise debounce field bits 7..3, codes 0..7 give 0 to 32 ms
// - noise debounce codes 8 and up give 64 ms times (code minus seven)
// - left signal debounce field bits 2..0, codes 0..7 give 0 to 32 ms
// - right channel has its own debounce register with the same layout
// - debounce times hold at normal rate only; double rate halves them
// - flag bit 7 high when left applied gain equals programmed gain
// - flag bit 6 high while left converter is powered up
// - flag bit 5 high while left signal is below noise threshold
// - flag bit 4 high while left loop applies its maximum allowed gain
// - flag bits 3..0 report the same four conditions for the right channel
// - threshold code zero disables detection; others select -30 to -90 dB in 2 dB steps
// - maximum gain programmable 0 to 59.5 dB in half-dB steps, resets to all ones
`default_nettype none
package agc_status_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_RGAIN = 8'h21;
    localparam logic [7:0] IDX_LDEB = 8'h22;
    localparam logic [7:0] IDX_RDEB = 8'h23;
    localparam logic [7:0] IDX_FLAGS = 8'h24;
    localparam logic [7:0] IDX_CTRL = 8'h40;
    localparam logic [7:0] IDX_LCFG = 8'h41;
    localparam logic [7:0] IDX_RCFG = 8'h42;
    localparam logic [7:0] IDX_IRQ_STS = 8'h43;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h44;
    // field positions
    localparam int NOISE_LSB = 3;
    localparam int THR_LSB = 0;
    localparam int MAXG_LSB = 8;
    localparam int CTRL_DRA_BIT = 0;
    // reset values, and the top effective maximum gain code
    localparam logic [7:0] DEB_RESET = 8'h00;
    localparam logic [4:0] THR_RESET = 5'h00;
    localparam logic [6:0] MAXG_RESET = 7'h7F;
    localparam logic [6:0] MAXG_TOP = 7'h77;
    localparam logic [3:0] IRQ_RESET = 4'h0;
    // noise threshold: -(THR_BASE_DB + THR_STEP_DB*code) dB
    localparam int THR_BASE_DB = 28;
    localparam int THR_STEP_DB = 2;
    // timing: the debounce unit is half a millisecond
    localparam int PCLK_NS = 25;
    localparam int HALF_MS_NS = 500000;
    localparam int HALF_MS_CYCLES = HALF_MS_NS / PCLK_NS;
    localparam logic [11:0] LONG_STEP = 12'h080;
    localparam logic [4:0] LONG_FROM = 5'h07;

    // debounce code to a count of half-millisecond ticks
    function automatic logic [11:0] deb_ticks(input logic [4:0] code);
        logic [11:0] t;
        t = 12'h000;
        if (code == 5'h00)
        begin
            t = 12'h000;
        end
        else if (code < 5'h08)
        begin
            t = 12'h001 << (code - 5'h01);
        end
        else
        begin
            t = 12'(LONG_STEP * (code - LONG_FROM));
        end
        return t;
    endfunction
endpackage
`default_nettype wire

// [rtl/agc_gate_debounce.sv]
`default_nettype none
module agc_gate_debounce
    import agc_status_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // time base and settings
    input wire logic tick,
    input wire logic enable,
    input wire logic [4:0] noise_code,
    input wire logic [2:0] signal_code,
    // condition
    input wire logic raw_below,
    output logic flag_r
);
    logic [11:0] cnt_r;
    logic [11:0] target;

    // going quiet uses the noise time, coming back the signal time
    assign target = raw_below ? deb_ticks(noise_code) : deb_ticks({2'b00, signal_code});

    // the counter restarts whenever the raw condition agrees with the flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= 12'h000;
            flag_r <= 1'b0;
        end
        else if (!enable)
        begin
            cnt_r <= 12'h000;
            flag_r <= 1'b0;
        end
        else if (raw_below == flag_r)
        begin
            cnt_r <= 12'h000;
        end
        else if (cnt_r >= target)
        begin
            flag_r <= raw_below;
            cnt_r <= 12'h000;
        end
        else if (tick)
        begin
            cnt_r <= cnt_r + 12'h001;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_disabled_clear: assert property (!enable |=> !flag_r) else $error("flag set while disabled");
    // a threshold write of zero clears the flag whatever the level, so only enabled moves count
    a_flag_cause: assert property ($changed(flag_r) && $past(enable) |-> flag_r == $past(raw_below))
        else $error("flag moved against raw condition");
    a_no_early: assert property (enable && raw_below != flag_r && cnt_r < target && target != 12'h000
        && $stable(raw_below) |=> $stable(flag_r) || !enable) else $error("flag moved before debounce");
endmodule
`default_nettype wire

// [tb/tb_agc_debounce_status.sv]
`default_nettype none
module tb_agc_debounce_status
    import agc_status_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // bench signals
    // ****************************************
    // short tick so long debounce codes fit the run
    localparam int HC = 8;
    logic pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata_r;
    logic pready_r, pslverr_r, left_below_r, right_below_r, irq_r;
    logic [7:0] la, ra, lp, rp;
    logic lpow, rpow;
    logic [6:0] latt, ratt;
    int miscompares, cmp_count, seed, n;
    logic [31:0] rv;
    logic er;
    logic [7:0] ri[6] = '{IDX_LDEB, IDX_RDEB, IDX_LCFG, IDX_RCFG, IDX_IRQ_MASK, IDX_CTRL};
    logic [31:0] re[6] = '{32'h0, 32'h0, 32'h7F00, 32'h7F00, 32'h0, 32'h0};
    int nl[11] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 31};

    // free-running 40 MHz clock
    always #12.5 pclk = ~pclk;

    agc_debounce_status #(.half_ms_cycles(HC)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
        .pready_r(pready_r), .pslverr_r(pslverr_r), .left_applied_gain(la), .right_applied_gain(ra),
        .left_programmed_gain(lp), .right_programmed_gain(rp), .left_adc_powered(lpow),
        .right_adc_powered(rpow), .left_level_atten(latt), .right_level_atten(ratt),
        .left_below_r(left_below_r), .right_below_r(right_below_r), .irq_r(irq_r));

    // ****************************************
    // helpers
    // ****************************************
    task close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; returns just after the edge that sampled pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready_r !== 1'b1 && k < 20)
        begin
            @(posedge pclk);
            k++;
        end
        if (k == 20)
        begin
            miscompares++;
            $display("ERROR %0t: no pready", $time);
            close_out();
        end
        rv = prdata_r;
        er = pslverr_r;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [11:0] ad(input logic [7:0] i);
        return {2'b00, i, 2'b00};
    endfunction

    // expected flag nibble of one channel: settled, powered, below 30 dB, at its ceiling
    function automatic logic [3:0] fl(input logic [7:0] a, p, input logic w, input logic [6:0] t, input logic [7:0] top);
        return {a == p, w, t > 30, a == top};
    endfunction

    // debounce code to half-millisecond ticks, worked out independently
    function automatic int tk(input int c);
        if (c == 0)
        begin
            return 0;
        end
        return (c < 8) ? (1 << (c - 1)) : 128 * (c - 7);
    endfunction

    task settle(input logic ch, input logic v);
        n = 0;
        while (((ch ? right_below_r : left_below_r) !== v) && n < 40000)
        begin
            @(posedge pclk);
            n++;
        end
        if (n == 40000)
        begin
            miscompares++;
            $display("ERROR %0t: flag never settled", $time);
            close_out();
        end
    endtask

    // tick phase is free-running, so allow one tick of slack before the nominal time
    task deb(input logic ch, input int nc, input int sc, input int hc);
        apb(1'b1, ad(ch ? IDX_RDEB : IDX_LDEB), 32'(nc * 8 + sc));
        ratt <= ch ? 7'h28 : ratt;
        latt <= ch ? latt : 7'h28;
        settle(ch, 1'b1);
        check(32'(n >= (tk(nc) - 1) * hc && n <= tk(nc) * hc + 5), 32'h1);
        ratt <= ch ? 7'h0A : ratt;
        latt <= ch ? latt : 7'h0A;
        settle(ch, 1'b0);
        check(32'(n >= (tk(sc) - 1) * hc && n <= tk(sc) * hc + 5), 32'h1);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        logic [7:0] a0, a1, p0, p1;
        logic w0, w1;
        logic [6:0] t0, t1;
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        {la, ra, lp, rp} = 32'h0;
        {lpow, rpow} = 2'b00;
        latt = 7'h00;
        ratt = 7'h00;
        miscompares = 0;
        cmp_count = 0;
        seed = 32'h7725aa5b;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b0, ad(ri[i]), 32'h0);
            check(rv, re[i]);
        end
        $display("test reset values done");
        a0 = 8'($random(seed));
        a1 = 8'($random(seed));
        apb(1'b1, ad(IDX_LDEB), {24'h0, a0});
        apb(1'b1, ad(IDX_RDEB), {24'h0, a1});
        apb(1'b0, ad(IDX_LDEB), 32'h0);
        check(rv, {24'h0, a0});
        apb(1'b0, ad(IDX_RDEB), 32'h0);
        check(rv, {24'h0, a1});
        apb(1'b0, 12'h0FC, 32'h0);
        check({31'h0, er}, 32'h1);
        check(rv, 32'h0);
        apb(1'b1, 12'h089, 32'h5);
        check({31'h0, er}, 32'h1);
        apb(1'b1, ad(IDX_LDEB), 32'h0);
        apb(1'b1, ad(IDX_RDEB), 32'h0);
        $display("test register access done");
        // gain and flag readback; left ceiling lowered to exercise the saturation compare
        apb(1'b1, ad(IDX_LCFG), 32'h2001);
        apb(1'b1, ad(IDX_RCFG), 32'h7F01);
        for (int i = 0; i < 12; i++)
        begin
            a0 = (i == 0) ? 8'h20 : ((i == 1) ? 8'hE8 : 8'($random(seed)));
            a1 = (i == 0) ? 8'h77 : ((i == 1) ? 8'h00 : 8'($random(seed)));
            p0 = ($random(seed) & 1) ? a0 : 8'($random(seed));
            p1 = ($random(seed) & 1) ? a1 : 8'($random(seed));
            {w0, w1} = (i == 0) ? 2'b11 : 2'($random(seed));
            t0 = (i == 0) ? 7'h28 : 7'($random(seed));
            t1 = (i == 0) ? 7'h0A : 7'($random(seed));
            la <= a0;
            ra <= a1;
            lp <= p0;
            rp <= p1;
            lpow <= w0;
            rpow <= w1;
            latt <= t0;
            ratt <= t1;
            repeat (6) @(posedge pclk);
            apb(1'b0, ad(IDX_RGAIN), 32'h0);
            check(rv, {24'h0, a1});
            apb(1'b0, ad(IDX_FLAGS), 32'h0);
            check(rv, {24'h0, fl(a0, p0, w0, t0, 8'h20), fl(a1, p1, w1, t1, 8'h77)});
        end
        apb(1'b1, ad(IDX_RGAIN), 32'hFF);
        apb(1'b0, ad(IDX_RGAIN), 32'h0);
        check(rv, {24'h0, a1});
        $display("test flags done");
        apb(1'b1, ad(IDX_LCFG), 32'h7F00);
        apb(1'b1, ad(IDX_RCFG), 32'h7F1F);
        latt <= 7'h7F;
        ratt <= 7'h5B;
        repeat (10) @(posedge pclk);
        check({31'h0, left_below_r}, 32'h0);
        check({31'h0, right_below_r}, 32'h1);
        ratt <= 7'h5A;
        repeat (10) @(posedge pclk);
        check({31'h0, right_below_r}, 32'h0);
        $display("test thresholds done");
        apb(1'b1, ad(IDX_LCFG), 32'h7F01);
        apb(1'b1, ad(IDX_RCFG), 32'h7F01);
        latt <= 7'h0A;
        ratt <= 7'h0A;
        repeat (10) @(posedge pclk);
        // a dip shorter than the noise time must not reach the flag
        apb(1'b1, ad(IDX_LDEB), 32'h28);
        latt <= 7'h28;
        repeat (60) @(posedge pclk);
        latt <= 7'h0A;
        repeat (150) @(posedge pclk);
        check({31'h0, left_below_r}, 32'h0);
        for (int i = 0; i < 11; i++)
        begin
            deb(1'b0, nl[i], i % 8, HC);
        end
        deb(1'b1, 8, 7, HC);
        deb(1'b1, 3, 2, HC);
        apb(1'b1, ad(IDX_CTRL), 32'h1);
        deb(1'b0, 6, 5, HC / 2);
        apb(1'b1, ad(IDX_CTRL), 32'h0);
        $display("test debounce done");
        check({31'h0, irq_r}, 32'h0);
        apb(1'b0, ad(IDX_IRQ_STS), 32'h0);
        check(rv & 32'h1, 32'h1);
        apb(1'b1, ad(IDX_IRQ_MASK), 32'h1);
        repeat (3) @(posedge pclk);
        check({31'h0, irq_r}, 32'h1);
        apb(1'b1, ad(IDX_IRQ_STS), 32'h1);
        repeat (3) @(posedge pclk);
        check({31'h0, irq_r}, 32'h0);
        apb(1'b0, ad(IDX_IRQ_STS), 32'h0);
        check(rv & 32'h1, 32'h0);
        $display("test interrupt done");
        close_out();
    end
endmodule
`default_nettype wire
